// ==== tws_pkg.sv ====
// tws_pkg: constants, state type and helpers of the two-wire control slave
// Notes on behaviour
// - slave only; clock in, data both ways
// - send one by releasing the data line
// - start is data falling while clock high
// - shift in eight identifier bits, msb first
// - identifier lsb one reads, zero writes
// - matching identifier acknowledged by pulling low
// - mismatch returns idle until next start
// - stop is data rising while clock high
// - misplaced start or stop abandons the transfer
// - eight-bit register address follows the identifier
// - sixteen-bit words, upper byte first, each acknowledged
// - single and auto-increment multiple reads and writes
// - every register readable over the link
// - receiver acknowledges low in ninth slot
// - sequencer busy blocks ordinary register access
package tws_pkg;

  localparam logic [3:0]  TWS_CNT_RST     = 4'h0;
  localparam logic [3:0]  TWS_FIRST_CNT   = 4'h1;
  localparam logic [3:0]  TWS_LAST_BIT    = 4'h7;
  localparam logic [3:0]  TWS_ACK_SLOT    = 4'h8;
  localparam logic [3:0]  TWS_HI_MSB      = 4'hf;
  localparam logic [7:0]  TWS_ADDR_RST    = 8'h00;
  localparam logic [15:0] TWS_WORD_RST    = 16'h0000;
  localparam logic [15:0] TWS_NO_DATA     = 16'hffff;
  localparam logic [7:0]  TWS_SEQ_FIRST   = 8'h6c;
  localparam logic [7:0]  TWS_SEQ_LAST    = 8'h70;
  localparam logic [7:0]  TWS_SWRST_ADDR  = 8'h00;
  localparam logic [7:0]  TWS_DEV_ID_DFLT = 8'h5a; // arbitrary value

  typedef enum logic [2:0] {
    TWS_IDLE,
    TWS_DEVID,
    TWS_REGA,
    TWS_WRHI,
    TWS_WRLO,
    TWS_RDHI,
    TWS_RDLO
  } tws_state_t;

  function automatic logic [7:0] tws_next(input logic [7:0] a);
    return a + 8'h01;
  endfunction : tws_next

endpackage : tws_pkg

// ==== tws_cond_if.sv ====
// tws_cond_if: start and stop condition toggles from the edge detector
`timescale 1ns/1ps
interface tws_cond_if;
  logic start_tgl;
  logic stop_tgl;
  modport det (output start_tgl, output stop_tgl);
  modport eng (input start_tgl, input stop_tgl);
endinterface : tws_cond_if

// ==== tws_sync.sv ====
// tws_sync: two-flop synchroniser for one level or toggle
`timescale 1ns/1ps
module tws_sync
  import tws_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : tws_sync

// ==== tws_cond_det.sv ====
// tws_cond_det: start and stop detection clocked by the data line itself
`timescale 1ns/1ps
module tws_cond_det
  import tws_pkg::*;
(
  input  wire logic sda_i,
  input  wire logic scl_i,
  input  wire logic rstn_i,
  tws_cond_if.det   cond
);
  // the serial clock may run faster than mclk, so conditions cannot be
  // oversampled; an sda edge with scl high is the condition by definition
  logic start_q;
  logic stop_q;

  always_ff @(negedge sda_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_q ^ scl_i;
    end
  end

  always_ff @(posedge sda_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= stop_q ^ scl_i;
    end
  end

  assign cond.start_tgl = start_q;
  assign cond.stop_tgl  = stop_q;
endmodule : tws_cond_det

// ==== tws_control_slave.sv ====
// tws_control_slave: two-wire control slave with register access port on mclk
`timescale 1ns/1ps
module tws_control_slave
  import tws_pkg::*;
#(
  parameter logic [7:0] DEV_ID = TWS_DEV_ID_DFLT // arbitrary value
) (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        ser_clk_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        sequencer_busy_flag_i,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic [7:0]       reg_addr_o,
  output logic [15:0]      reg_wdata_o,
  input  wire logic [15:0] reg_rdata_i,
  output logic             refused_o
);

  ////////////////////////////////////////////////////////////////////////////
  // link side, on the serial clock

  tws_cond_if cond ();

  tws_cond_det u_cond (
    .sda_i  (sda_i),
    .scl_i  (ser_clk_i),
    .rstn_i (rstn_i),
    .cond   (cond)
  );

  tws_state_t  st_q;
  tws_state_t  st_d;
  logic [3:0]  cnt_q;
  logic [3:0]  cnt_d;
  logic [7:0]  sh_q;
  logic [7:0]  sh_d;
  logic [7:0]  addr_q;
  logic [7:0]  addr_d;
  logic [7:0]  hi_q;
  logic [7:0]  hi_d;
  logic [15:0] tx_q;
  logic [15:0] tx_d;
  logic        ack_q;
  logic        ack_d;
  logic        rw_q;
  logic        rw_d;
  logic        oe_q;
  logic        oe_d;
  logic        start_seen_q;
  logic        stop_seen_q;
  logic        req_tgl_q;
  logic        req_tgl_d;
  logic        req_wr_q;
  logic        req_wr_d;
  logic [7:0]  req_addr_q;
  logic [7:0]  req_addr_d;
  logic [15:0] req_data_q;
  logic [15:0] req_data_d;
  logic        ack_sync;
  logic [15:0] rd_word_q;
  logic        ack_tgl_q;

  logic        start_ev;
  logic        stop_ev;
  logic        start_ok;
  logic [7:0]  byte_w;
  logic        id_match;
  logic        fetched;
  logic [15:0] fetch_word;
  logic        rd_st;
  logic [3:0]  bidx;
  logic        tx_bit;

  // toggles settle while scl is high, half a period before the next rise
  assign start_ev   = cond.start_tgl ^ start_seen_q;
  assign stop_ev    = cond.stop_tgl ^ stop_seen_q;
  assign start_ok   = (st_q == TWS_IDLE) || (cnt_q == TWS_FIRST_CNT);
  assign byte_w     = {sh_q[6:0], sda_i};
  assign id_match   = (byte_w[7:1] == DEV_ID[7:1]);
  assign fetched    = (ack_sync == req_tgl_q);
  // a fetch that has not come back in time answers all ones
  assign fetch_word = fetched ? rd_word_q : TWS_NO_DATA;
  assign rd_st      = (st_q == TWS_RDHI) || (st_q == TWS_RDLO);
  assign bidx       = (st_q == TWS_RDHI) ? (TWS_HI_MSB - cnt_q) : (TWS_LAST_BIT - cnt_q);
  assign tx_bit     = tx_q[bidx];

  tws_sync u_ack_sync (
    .clk_i  (ser_clk_i),
    .rstn_i (rstn_i),
    .d_i    (ack_tgl_q),
    .q_o    (ack_sync)
  );

  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    sh_d       = sh_q;
    addr_d     = addr_q;
    hi_d       = hi_q;
    tx_d       = tx_q;
    ack_d      = 1'b0;
    rw_d       = rw_q;
    req_tgl_d  = req_tgl_q;
    req_wr_d   = req_wr_q;
    req_addr_d = req_addr_q;
    req_data_d = req_data_q;
    if (start_ev && start_ok) begin
      st_d  = TWS_DEVID;
      cnt_d = TWS_FIRST_CNT;
      sh_d  = byte_w;
    end else if (start_ev || stop_ev) begin
      st_d  = TWS_IDLE;
      cnt_d = TWS_CNT_RST;
    end else if (st_q != TWS_IDLE && cnt_q != TWS_ACK_SLOT) begin
      sh_d  = byte_w;
      cnt_d = cnt_q + 4'h1;
      if (cnt_q == TWS_LAST_BIT) begin
        unique case (st_q)
          TWS_DEVID: begin
            if (id_match) begin
              ack_d = 1'b1;
              rw_d  = sda_i;
            end else begin
              st_d  = TWS_IDLE;
              cnt_d = TWS_CNT_RST;
            end
          end
          TWS_REGA: begin
            ack_d      = 1'b1;
            addr_d     = byte_w;
            req_tgl_d  = ~req_tgl_q;
            req_wr_d   = 1'b0;
            req_addr_d = byte_w;
          end
          TWS_WRHI: begin
            ack_d = 1'b1;
            hi_d  = byte_w;
          end
          TWS_WRLO: begin
            ack_d      = 1'b1;
            addr_d     = tws_next(addr_q);
            req_tgl_d  = ~req_tgl_q;
            req_wr_d   = 1'b1;
            req_addr_d = addr_q;
            req_data_d = {hi_q, byte_w};
          end
          TWS_IDLE, TWS_RDHI, TWS_RDLO: begin
          end
        endcase
      end
    end else if (cnt_q == TWS_ACK_SLOT) begin
      cnt_d = TWS_CNT_RST;
      unique case (st_q)
        TWS_DEVID: begin
          if (rw_q) begin
            st_d       = TWS_RDHI;
            tx_d       = fetch_word;
            req_tgl_d  = ~req_tgl_q;
            req_wr_d   = 1'b0;
            req_addr_d = tws_next(addr_q);
          end else begin
            st_d = TWS_REGA;
          end
        end
        TWS_REGA: st_d = TWS_WRHI;
        TWS_WRHI: st_d = TWS_WRLO;
        TWS_WRLO: st_d = TWS_WRHI;
        TWS_RDHI: st_d = sda_i ? TWS_IDLE : TWS_RDLO;
        TWS_RDLO: begin
          if (!sda_i) begin
            st_d       = TWS_RDHI;
            addr_d     = tws_next(addr_q);
            tx_d       = fetch_word;
            req_tgl_d  = ~req_tgl_q;
            req_wr_d   = 1'b0;
            req_addr_d = tws_next(tws_next(addr_q));
          end else begin
            st_d = TWS_IDLE;
          end
        end
        TWS_IDLE: begin
        end
      endcase
    end
  end

  always_ff @(posedge ser_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q         <= TWS_IDLE;
      cnt_q        <= TWS_CNT_RST;
      sh_q         <= TWS_ADDR_RST;
      addr_q       <= TWS_ADDR_RST;
      hi_q         <= TWS_ADDR_RST;
      tx_q         <= TWS_WORD_RST;
      ack_q        <= 1'b0;
      rw_q         <= 1'b0;
      start_seen_q <= 1'b0;
      stop_seen_q  <= 1'b0;
      req_tgl_q    <= 1'b0;
      req_wr_q     <= 1'b0;
      req_addr_q   <= TWS_ADDR_RST;
      req_data_q   <= TWS_WORD_RST;
    end else begin
      st_q         <= st_d;
      cnt_q        <= cnt_d;
      sh_q         <= sh_d;
      addr_q       <= addr_d;
      hi_q         <= hi_d;
      tx_q         <= tx_d;
      ack_q        <= ack_d;
      rw_q         <= rw_d;
      start_seen_q <= cond.start_tgl;
      stop_seen_q  <= cond.stop_tgl;
      req_tgl_q    <= req_tgl_d;
      req_wr_q     <= req_wr_d;
      req_addr_q   <= req_addr_d;
      req_data_q   <= req_data_d;
    end
  end

  // data changes only while scl is low, so the drive moves on the falling edge
  assign oe_d = ((cnt_q == TWS_ACK_SLOT) && ack_q) || (rd_st && (cnt_q != TWS_ACK_SLOT) && !tx_bit);

  always_ff @(negedge ser_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // register side, on mclk

  logic       req_sync;
  logic       req_seen_q;
  logic       req_new;
  logic       exempt;
  logic       allowed;
  logic       wr_q;
  logic       rd_q;
  logic       refused_q;
  logic [7:0] raddr_q;
  logic [15:0] wdata_q;
  logic       done;

  tws_sync u_req_sync (
    .clk_i  (mclk_i),
    .rstn_i (rstn_i),
    .d_i    (req_tgl_q),
    .q_o    (req_sync)
  );

  // request payload is held by the link side until the next toggle
  assign req_new = req_sync ^ req_seen_q;
  assign exempt  = ((req_addr_q >= TWS_SEQ_FIRST) && (req_addr_q <= TWS_SEQ_LAST)) || (req_addr_q == TWS_SWRST_ADDR);
  assign allowed = !sequencer_busy_flag_i || exempt;
  assign done    = wr_q || rd_q || refused_q;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_seen_q <= 1'b0;
      wr_q       <= 1'b0;
      rd_q       <= 1'b0;
      refused_q  <= 1'b0;
      raddr_q    <= TWS_ADDR_RST;
      wdata_q    <= TWS_WORD_RST;
      rd_word_q  <= TWS_WORD_RST;
      ack_tgl_q  <= 1'b0;
    end else begin
      req_seen_q <= req_sync;
      wr_q       <= req_new && req_wr_q && allowed;
      rd_q       <= req_new && !req_wr_q && allowed;
      refused_q  <= req_new && !allowed;
      ack_tgl_q  <= ack_tgl_q ^ done;
      if (req_new) begin
        raddr_q <= req_addr_q;
        wdata_q <= req_data_q;
      end
      if (rd_q) begin
        rd_word_q <= reg_rdata_i;
      end else if (refused_q) begin
        rd_word_q <= TWS_WORD_RST;
      end
    end
  end

  assign reg_wr_o    = wr_q;
  assign reg_rd_o    = rd_q;
  assign reg_addr_o  = raddr_q;
  assign reg_wdata_o = wdata_q;
  assign refused_o   = refused_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_start_frames : assert property (
    @(posedge ser_clk_i) disable iff (!rstn_i)
    start_ev && start_ok |=> st_q == TWS_DEVID && cnt_q == TWS_FIRST_CNT)
    else $error("start did not open an identifier byte");

  a_match_acks : assert property (
    @(posedge ser_clk_i) disable iff (!rstn_i)
    st_q == TWS_DEVID && cnt_q == TWS_LAST_BIT && id_match && !start_ev && !stop_ev
    |=> ack_q && cnt_q == TWS_ACK_SLOT ##1 !sda_oe_o || rd_st)
    else $error("matching identifier not acknowledged");

  a_mismatch_idle : assert property (
    @(posedge ser_clk_i) disable iff (!rstn_i)
    st_q == TWS_DEVID && cnt_q == TWS_LAST_BIT && !id_match && !start_ev && !stop_ev |=> st_q == TWS_IDLE)
    else $error("mismatching identifier not dropped");

  a_idle_released : assert property (
    @(posedge ser_clk_i) disable iff (!rstn_i)
    st_q == TWS_IDLE |-> !sda_oe_o)
    else $error("data line driven while idle");

  a_ack_slot_low : assert property (
    @(posedge ser_clk_i) disable iff (!rstn_i)
    cnt_q == TWS_ACK_SLOT && ack_q |-> sda_oe_o)
    else $error("acknowledge slot not pulled low");

  a_stop_idles : assert property (
    @(posedge ser_clk_i) disable iff (!rstn_i)
    stop_ev && !start_ev |=> st_q == TWS_IDLE)
    else $error("stop did not return to idle");

  a_misplaced_start : assert property (
    @(posedge ser_clk_i) disable iff (!rstn_i)
    start_ev && !start_ok |=> st_q == TWS_IDLE && cnt_q == TWS_CNT_RST)
    else $error("mid-byte start not abandoned");

  a_read_dir : assert property (
    @(posedge ser_clk_i) disable iff (!rstn_i)
    st_q == TWS_DEVID && cnt_q == TWS_ACK_SLOT && !start_ev && !stop_ev
    |=> st_q == ($past(rw_q) ? TWS_RDHI : TWS_REGA))
    else $error("direction bit not followed");

  a_read_bits : assert property (
    @(posedge ser_clk_i) disable iff (!rstn_i)
    rd_st && cnt_q != TWS_ACK_SLOT |-> sda_oe_o == !tx_bit)
    else $error("read data bit on the line is wrong");

  a_write_autoinc : assert property (
    @(posedge ser_clk_i) disable iff (!rstn_i)
    st_q == TWS_WRLO && cnt_q == TWS_LAST_BIT && !start_ev && !stop_ev
    |=> addr_q == tws_next($past(addr_q)) && req_wr_q && req_addr_q == $past(addr_q))
    else $error("write word did not advance the address");

  a_busy_refuses : assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    req_new && sequencer_busy_flag_i && !exempt |=> refused_o && !reg_wr_o && !reg_rd_o)
    else $error("access passed while sequencer busy");

  a_read_fetches : assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    req_new && !req_wr_q && allowed |=> reg_rd_o ##1 rd_word_q == $past(reg_rdata_i))
    else $error("read request did not fetch the word");

  c_write_word : cover property (@(posedge mclk_i) disable iff (!rstn_i) reg_wr_o);
  c_read_word  : cover property (@(posedge ser_clk_i) disable iff (!rstn_i)
    st_q == TWS_RDLO && cnt_q == TWS_ACK_SLOT && !sda_i);
  c_mismatch   : cover property (@(posedge ser_clk_i) disable iff (!rstn_i)
    st_q == TWS_DEVID && cnt_q == TWS_LAST_BIT && !id_match);
  c_refused    : cover property (@(posedge mclk_i) disable iff (!rstn_i) refused_o);

endmodule : tws_control_slave

// ==== tws_master_model.sv ====
// tws_master_model: behavioural two-wire bus master with pull-up line resolution
`timescale 1ns/1ps
module tws_master_model #(
  parameter int GAP_NS = 400
) (
  input  wire logic dev_oe_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic m_low;

  // pull-up wins unless some party pulls the line low
  assign sda_o = (m_low | dev_oe_i) ? 1'b0 : 1'b1;
  initial begin
    m_low = 1'b0;
    scl_o = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic start_cond();
    #2 m_low = 1'b0;
    #5.5 scl_o = 1'b1;
    #4 m_low = 1'b1;
    #3.5 scl_o = 1'b0;
  endtask : start_cond

  // clock then stands still high between frames
  task automatic stop_cond();
    #2 m_low = 1'b1;
    #5.5 scl_o = 1'b1;
    #4 m_low = 1'b0;
    #(GAP_NS);
  endtask : stop_cond

  // data moves 2 ns after the clock falls, never while it is high
  task automatic put_bit(input logic b);
    #2 m_low = ~b;
    #5.5 scl_o = 1'b1;
    #7.5 scl_o = 1'b0;
  endtask : put_bit

  // the gap stretches the low clock so the slow side has time to fetch
  task automatic send_byte(input logic [7:0] b, output logic acked);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    #2 m_low = 1'b0;
    #5.5 scl_o = 1'b1;
    acked = ~sda_o;
    #7.5 scl_o = 1'b0;
    #(GAP_NS);
  endtask : send_byte

  task automatic recv_byte(input logic last, output logic [7:0] b);
    #2 m_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #5.5 scl_o = 1'b1;
      b[i] = sda_o;
      #7.5 scl_o = 1'b0;
      #2;
    end
    m_low = ~last;
    #5.5 scl_o = 1'b1;
    #7.5 scl_o = 1'b0;
    #2 m_low = 1'b0;
    #(GAP_NS);
  endtask : recv_byte
endmodule : tws_master_model

// ==== testbench.sv ====
// testbench: self-checking bench for the two-wire control slave
`timescale 1ns/1ps
module testbench;
  import tws_pkg::*;
  localparam logic [7:0] ID_W  = {TWS_DEV_ID_DFLT[7:1], 1'b0};
  localparam logic [7:0] ID_R  = {TWS_DEV_ID_DFLT[7:1], 1'b1};
  localparam int         LIMIT = 6000;
  logic        mclk_i, rstn_i, busy, scl, line, sda_o, oe, wr, rd, refused;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata;
  logic [15:0] regs [256];
  int          failures, samples_checked, wr_count, ref_count, cycles;

  tws_control_slave tws_control_slave_inst (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .ser_clk_i(scl), .sda_i(line), .sda_o(sda_o),
    .sda_oe_o(oe), .sequencer_busy_flag_i(busy), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata), .refused_o(refused)
  );
  tws_master_model tws_master_model_inst (.dev_oe_i(oe), .scl_o(scl), .sda_o(line));

  // read data must be valid in the strobe cycle, so it follows the address directly
  assign rdata = regs[addr];

  // master clock never stops, so the host needs no clock-enable precaution
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (wr === 1'b1) begin
      regs[addr] <= wdata;
      wr_count <= wr_count + 1;
    end
    if (refused === 1'b1) ref_count <= ref_count + 1;
    if (cycles == LIMIT) begin
      failures = failures + 1;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] seed_val(input logic [7:0] a);
    return {a, ~a};
  endfunction : seed_val

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tx(input logic [7:0] b, input logic exp_ack);
    logic a;
    tws_master_model_inst.send_byte(b, a);
    check("ack", {15'h0, a}, {15'h0, exp_ack});
  endtask : tx

  task automatic write_frame(input logic [7:0] a, input logic [15:0] w0, input logic [15:0] w1, input int n);
    logic [15:0] w;
    tws_master_model_inst.start_cond();
    tx(ID_W, 1'b1);
    tx(a, 1'b1);
    for (int k = 0; k < n; k++) begin
      w = (k == 0) ? w0 : w1;
      tx(w[15:8], 1'b1);
      tx(w[7:0], 1'b1);
    end
    tws_master_model_inst.stop_cond();
    repeat (20) @(negedge mclk_i);
  endtask : write_frame

  task automatic read_check(input logic [7:0] a, input int n, input logic [15:0] e0, input logic [15:0] e1,
                            input logic [15:0] e2);
    logic [7:0]  hi, lo;
    logic [15:0] e;
    tws_master_model_inst.start_cond();
    tx(ID_W, 1'b1);
    tx(a, 1'b1);
    tws_master_model_inst.start_cond();
    tx(ID_R, 1'b1);
    for (int k = 0; k < n; k++) begin
      e = (k == 0) ? e0 : ((k == 1) ? e1 : e2);
      tws_master_model_inst.recv_byte(1'b0, hi);
      tws_master_model_inst.recv_byte(k == n - 1, lo);
      check("read word", {hi, lo}, e);
    end
    tws_master_model_inst.stop_cond();
  endtask : read_check

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("reset strobes", {oe, wr, rd, refused, 12'h0}, 16'h0000);
    check("reset addr", {8'h00, addr}, 16'h0000);
    check("reset wdata", wdata, 16'h0000);
    check("data out", {15'h0, sda_o}, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  // two words across the top of the map, then read three so the address wraps
  task automatic t_write_read();
    int n;
    n = wr_count;
    write_frame(8'hfe, 16'h1234, 16'habcd, 2);
    check("write count", 16'(wr_count - n), 16'h0002);
    check("word fe", regs[8'hfe], 16'h1234);
    check("word ff", regs[8'hff], 16'habcd);
    read_check(8'h05, 1, seed_val(8'h05), 16'h0000, 16'h0000);
    read_check(8'hfe, 3, 16'h1234, 16'habcd, seed_val(8'h00));
    $display("test write_read done");
  endtask : t_write_read

  task automatic t_mismatch();
    int n;
    n = wr_count;
    tws_master_model_inst.start_cond();
    tx(ID_W ^ 8'h80, 1'b0);
    tx(8'h30, 1'b0);
    tx(8'h11, 1'b0);
    tws_master_model_inst.stop_cond();
    repeat (20) @(negedge mclk_i);
    check("ignored frame", 16'(wr_count - n), 16'h0000);
    $display("test mismatch done");
  endtask : t_mismatch

  // lone upper byte before stop, then a start in mid-byte
  task automatic t_abort();
    int n;
    n = wr_count;
    tws_master_model_inst.start_cond();
    tx(ID_W, 1'b1);
    tx(8'h20, 1'b1);
    tx(8'h99, 1'b1);
    tws_master_model_inst.stop_cond();
    tws_master_model_inst.put_bit(1'b1);
    tws_master_model_inst.start_cond();
    tx(ID_W, 1'b1);
    tx(8'h21, 1'b1);
    tws_master_model_inst.put_bit(1'b1);
    tws_master_model_inst.put_bit(1'b0);
    tws_master_model_inst.put_bit(1'b1);
    tws_master_model_inst.put_bit(1'b1);
    tws_master_model_inst.start_cond();
    tws_master_model_inst.stop_cond();
    repeat (20) @(negedge mclk_i);
    check("aborted writes", 16'(wr_count - n), 16'h0000);
    check("word 20", regs[8'h20], seed_val(8'h20));
    write_frame(8'h22, 16'h0f0f, 16'h0000, 1);
    check("word 22", regs[8'h22], 16'h0f0f);
    $display("test abort done");
  endtask : t_abort

  task automatic t_busy();
    int n;
    @(negedge mclk_i);
    busy = 1'b1;
    n = ref_count;
    write_frame(8'h10, 16'h5555, 16'h0000, 1);
    check("blocked word", regs[8'h10], seed_val(8'h10));
    check("refusal seen", {15'h0, ref_count > n}, 16'h0001);
    write_frame(8'h6c, 16'h6c6c, 16'h0000, 1);
    check("sequencer word", regs[8'h6c], 16'h6c6c);
    read_check(8'h10, 1, 16'h0000, 16'h0000, 16'h0000);
    @(negedge mclk_i);
    busy = 1'b0;
    $display("test busy done");
  endtask : t_busy

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn_i = 1'b0;
    busy = 1'b0;
    failures = 0;
    samples_checked = 0;
    wr_count = 0;
    ref_count = 0;
    cycles = 0;
    for (int i = 0; i < 256; i++) regs[i] = seed_val(8'(i));
    repeat (5) @(negedge mclk_i);
    t_reset();
    repeat (5) @(negedge mclk_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    t_write_read();
    t_mismatch();
    t_abort();
    t_busy();
    report_and_stop();
  end
endmodule : testbench
